/* rtl/rcs_pkg.sv */
package rcs_pkg;

  // ***************************************************************
  // Bus geometry and limits
  // ***************************************************************
  localparam int RCS_BYTE_W = 8;
  localparam int RCS_CNT_W = 5;
  localparam logic [4:0] RCS_MAX_BYTES = 5'h13;
  localparam logic [4:0] RCS_POWER_MAX_BYTES = 5'h06;
  localparam int RCS_SEL_W = 6;

  // ***************************************************************
  // Timing and sizing defaults
  // ***************************************************************
  localparam int RCS_HALF_DIV = 4;
  localparam int RCS_SVC_BYTES = 1;
  localparam int RCS_FIFO_DEPTH = 16;
  localparam logic [7:0] RCS_IDLE_TX = 8'h00;

  // ***************************************************************
  // Targets and commands
  // ***************************************************************
  typedef enum logic [2:0] {
    RCS_TGT_SHARED,
    RCS_TGT_CODEPLUG,
    RCS_TGT_VOICE,
    RCS_TGT_EXP1,
    RCS_TGT_EXP2,
    RCS_TGT_OPTION
  } rcs_tgt_e;

  typedef struct packed {
    rcs_tgt_e target;
    logic [RCS_CNT_W-1:0] nbytes;
  } rcs_cmd_s;

endpackage : rcs_pkg

/* rtl/rcs_spi_master.sv */
`timescale 1ns/1ps

// ***************************************************************
// Write data buffer
// ***************************************************************
module rcs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk_sys, // System clock.
  input wire logic rst_n, // Asynchronous reset.
  input wire logic in_valid, // Write request.
  output logic in_ready, // Not full.
  input wire logic [WIDTH-1:0] in_data, // Write word.
  output logic out_valid, // Not empty.
  input wire logic out_ready, // Pop request.
  output logic [WIDTH-1:0] out_data, // Head word.
  output logic [$clog2(DEPTH+1)-1:0] count // Words held.
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin
      $error("rcs_fifo depth must be a power of two");
    end
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  wire push = in_valid && in_ready;
  wire pop = out_ready && out_valid;
  wire [CW-1:0] next_count = count + CW'(push) - CW'(pop);

  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready <= 1'b0;
    end else begin
      wr_ptr <= wr_ptr + AW'(push);
      rd_ptr <= rd_ptr + AW'(pop);
      count <= next_count;
      in_ready <= (next_count != CW'(DEPTH));
    end
  end
endmodule : rcs_fifo

// ***************************************************************
// Serial bus master
// ***************************************************************
module rcs_spi_master import rcs_pkg::*; #(
  parameter int HALF_DIV = RCS_HALF_DIV,
  parameter int SVC_BYTES = RCS_SVC_BYTES,
  parameter int FIFO_DEPTH = RCS_FIFO_DEPTH
) (
  input wire logic clk_sys, // System clock.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic cmd_valid, // Transfer request.
  output logic cmd_ready, // Idle and able to take a request.
  input wire rcs_cmd_s cmd, // Target and byte count.
  input wire logic wr_valid, // Outbound byte offered.
  output logic wr_ready, // Buffer has room.
  input wire logic [7:0] wr_data, // Outbound byte.
  output logic rd_valid, // Inbound byte pulse.
  output logic [7:0] rd_data, // Inbound byte.
  output logic busy, // Transfer in progress.
  output logic spi_clk, // Serial clock.
  output logic spi_mosi, // Outbound serial data.
  input wire logic spi_miso, // Inbound serial data.
  input wire logic svc_request, // Option board service request.
  output logic shared_peripheral_select_n, // Shared select.
  output logic codeplug_memory_select_n, // Codeplug select.
  output logic voice_storage_select_n, // Voice storage select.
  output logic expansion_one_select_n, // Expansion one select.
  output logic expansion_two_select_n, // Expansion two select.
  output logic option_board_select_n // Option board select.
);
  localparam int CW = $clog2(FIFO_DEPTH+1);

  initial begin
    if (HALF_DIV < 3 || HALF_DIV > 255) begin
      $error("HALF_DIV must lie in 3..255");
    end
    if (SVC_BYTES < 1 || SVC_BYTES > int'(RCS_MAX_BYTES)) begin
      $error("SVC_BYTES out of range");
    end
  end

  function automatic logic [RCS_SEL_W-1:0] sel_of(input rcs_tgt_e t);
    sel_of = RCS_SEL_W'(1) << t;
  endfunction : sel_of

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETUP,
    ST_LOW,
    ST_HIGH,
    ST_HOLD
  } rcs_state_e;

  // ***************************************************************
  // Input synchronisers and buffer
  // ***************************************************************
  logic miso_meta;
  logic miso_s;
  logic svc_meta;
  logic svc_s;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      miso_meta <= 1'b0;
      miso_s <= 1'b0;
      svc_meta <= 1'b0;
      svc_s <= 1'b0;
    end else begin
      miso_meta <= spi_miso;
      miso_s <= miso_meta;
      svc_meta <= svc_request;
      svc_s <= svc_meta;
    end
  end

  logic fifo_pop;
  logic fifo_valid;
  logic [7:0] fifo_data;
  logic [CW-1:0] fifo_count;

  rcs_fifo #(.WIDTH(RCS_BYTE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .in_valid(wr_valid),
    .in_ready(wr_ready),
    .in_data(wr_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data),
    .count(fifo_count)
  );

  // ***************************************************************
  // Sequencer decode
  // ***************************************************************
  rcs_state_e state;
  logic [7:0] div;
  logic [2:0] bit_idx;
  logic [RCS_CNT_W-1:0] bytes_left;
  logic from_fifo;
  logic is_option;
  logic [7:0] tx_sh;
  logic [7:0] rx_sh;
  logic [RCS_SEL_W-1:0] sel_n;

  wire div_end = (div == 8'(HALF_DIV - 1));
  wire [RCS_CNT_W-1:0] nb_req = (cmd.nbytes == '0) ? RCS_CNT_W'(1) :
    (cmd.nbytes > RCS_MAX_BYTES) ? RCS_MAX_BYTES : cmd.nbytes;
  wire fifo_enough = (fifo_count >= CW'(nb_req));
  wire go_cmd = cmd_valid && cmd_ready && fifo_enough;
  wire go_svc = (state == ST_IDLE) && !cmd_valid && svc_s;
  wire load_now = (state == ST_SETUP && div_end) ||
    (state == ST_HIGH && div_end && bit_idx == 3'h0 && bytes_left != 1);
  wire [7:0] next_byte = from_fifo ? fifo_data : RCS_IDLE_TX;
  wire [7:0] next_rx = {rx_sh[6:0], miso_s};
  wire last_done = (state == ST_HIGH) && div_end && bit_idx == 3'h0;

  assign fifo_pop = load_now && from_fifo;

  assign shared_peripheral_select_n = sel_n[RCS_TGT_SHARED];
  assign codeplug_memory_select_n = sel_n[RCS_TGT_CODEPLUG];
  assign voice_storage_select_n = sel_n[RCS_TGT_VOICE];
  assign expansion_one_select_n = sel_n[RCS_TGT_EXP1];
  assign expansion_two_select_n = sel_n[RCS_TGT_EXP2];
  assign option_board_select_n = sel_n[RCS_TGT_OPTION];

  // ***************************************************************
  // Sequencer
  // ***************************************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      div <= 8'h00;
      bit_idx <= 3'h0;
      bytes_left <= '0;
      from_fifo <= 1'b0;
      is_option <= 1'b0;
      tx_sh <= 8'h00;
      rx_sh <= 8'h00;
      sel_n <= '1;
      spi_clk <= 1'b0;
      spi_mosi <= 1'b0;
      cmd_ready <= 1'b0;
      busy <= 1'b0;
      rd_valid <= 1'b0;
      rd_data <= 8'h00;
    end else begin
      rd_valid <= 1'b0;
      div <= div_end ? 8'h00 : div + 8'h01;
      unique case (state)
        ST_IDLE: begin
          div <= 8'h00;
          cmd_ready <= 1'b1;
          if (go_cmd || go_svc) begin
            state <= ST_SETUP;
            cmd_ready <= 1'b0;
            busy <= 1'b1;
            from_fifo <= go_cmd;
            is_option <= go_cmd ? (cmd.target == RCS_TGT_OPTION) : 1'b1;
            bytes_left <= go_cmd ? nb_req : RCS_CNT_W'(SVC_BYTES);
            sel_n <= go_cmd ? ~sel_of(cmd.target) :
              ~sel_of(RCS_TGT_OPTION);
          end
        end
        ST_SETUP: begin
          if (div_end) begin
            state <= ST_LOW;
            tx_sh <= {next_byte[6:0], 1'b0};
            spi_mosi <= next_byte[7];
            bit_idx <= 3'h7;
          end
        end
        ST_LOW: begin
          if (div_end) begin
            state <= ST_HIGH;
            spi_clk <= 1'b1;
          end
        end
        ST_HIGH: begin
          if (div_end) begin
            spi_clk <= 1'b0;
            rx_sh <= next_rx;
            bit_idx <= bit_idx - 3'h1;
            state <= ST_LOW;
            if (bit_idx != 3'h0) begin
              spi_mosi <= tx_sh[7];
              tx_sh <= {tx_sh[6:0], 1'b0};
            end else begin
              bytes_left <= bytes_left - RCS_CNT_W'(1);
              rd_valid <= is_option;
              rd_data <= next_rx;
              if (bytes_left == RCS_CNT_W'(1)) begin
                state <= ST_HOLD;
              end else begin
                tx_sh <= {next_byte[6:0], 1'b0};
                spi_mosi <= next_byte[7];
              end
            end
          end
        end
        ST_HOLD: begin
          if (div_end) begin
            state <= ST_IDLE;
            sel_n <= '1;
            busy <= 1'b0;
            spi_mosi <= 1'b0;
          end
        end
      endcase
    end
  end

  // ***************************************************************
  // Checks
  // ***************************************************************
  logic [7:0] hi_len;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      hi_len <= 8'h00;
    end else begin
      hi_len <= spi_clk ? hi_len + 8'h01 : 8'h00;
    end
  end

  AST_QUIET_IDLE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state == ST_IDLE) |-> !spi_clk && (sel_n == '1))
    else $error("clock or select active while idle");
  AST_HIGH_WIDTH: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $fell(spi_clk) |-> (hi_len == 8'(HALF_DIV)))
    else $error("clock high phase has wrong width");
  AST_SEL_BEFORE_CLK: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    $rose(spi_clk) |-> (sel_n != '1) && $past(sel_n != '1, 2))
    else $error("clock rose without a select asserted");
  AST_MOSI_STABLE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    spi_clk && $past(spi_clk) |-> $stable(spi_mosi))
    else $error("outbound data moved while clock high");
  AST_ONE_SELECT: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $onehot0(~sel_n))
    else $error("more than one select asserted");
  AST_READ_OPTION: assert property (@(posedge clk_sys) disable iff (!rst_n)
    rd_valid |-> !option_board_select_n && $past(last_done))
    else $error("inbound byte outside an option transfer");
  AST_SVC_SELECT: assert property (@(posedge clk_sys) disable iff (!rst_n)
    go_svc |=> !option_board_select_n ##[1:300] spi_clk)
    else $error("service request did not start an option transfer");
  AST_END_RELEASE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state == ST_HOLD) && div_end |=> (sel_n == '1) && !spi_clk
    && !busy)
    else $error("select not released at end of transfer");
  AST_BYTE_LIMIT: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state == ST_SETUP) |-> (bytes_left <= RCS_MAX_BYTES)
    && (bytes_left != '0))
    else $error("byte count outside 1..19");
endmodule : rcs_spi_master

/* test/radio_controller_spi_bus_tb_top.sv */
`timescale 1ns/1ps

// ***************************************************************
// Testbench
// ***************************************************************
module radio_controller_spi_bus_tb_top;
  import rcs_pkg::*;
  logic clk_sys, rst_n, cmd_valid, cmd_ready, wr_valid, wr_ready;
  logic rd_valid, busy, spi_clk, spi_mosi, spi_miso, svc_request, svc_want;
  logic [7:0] wr_data, rd_data, last_rd;
  logic [5:0] sel_n;
  rcs_cmd_s cmd;
  int mismatches, cmp_count, cyc, rd_cnt, k, r;
  rcs_tgt_e tg[7] = '{RCS_TGT_SHARED, RCS_TGT_CODEPLUG, RCS_TGT_VOICE,
    RCS_TGT_EXP1, RCS_TGT_EXP2, RCS_TGT_OPTION, RCS_TGT_SHARED};
  logic [4:0] nb[7] = '{5'h13, 5'h01, 5'h00, 5'h03, 5'h02, 5'h02, 5'h06};

  rcs_spi_master #(.FIFO_DEPTH(32)) dut_u (.clk_sys(clk_sys), .rst_n(rst_n),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data),
    .rd_valid(rd_valid), .rd_data(rd_data), .busy(busy),
    .spi_clk(spi_clk), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
    .svc_request(svc_request),
    .shared_peripheral_select_n(sel_n[0]),
    .codeplug_memory_select_n(sel_n[1]), .voice_storage_select_n(sel_n[2]),
    .expansion_one_select_n(sel_n[3]), .expansion_two_select_n(sel_n[4]),
    .option_board_select_n(sel_n[5]));

  rcs_periph_model m_u (.spi_clk(spi_clk), .spi_mosi(spi_mosi),
    .sel_n(sel_n), .spi_miso(spi_miso), .svc_want(svc_want),
    .svc_request(svc_request));

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cyc++;
    if (rd_valid === 1'b1) begin
      rd_cnt++;
      last_rd = rd_data;
    end
    if (cyc == 60000) begin
      mismatches++;
      results();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk

  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : results

  task automatic finish_xfer(input int e, input logic [7:0] base);
    int j;
    j = 0;
    while (busy === 1'b1 && j < 3000) begin
      @(negedge clk_sys);
      j++;
    end
    @(negedge clk_sys);
    chk(spi_clk, 0);
    chk(m_u.got.size(), e);
    for (j = 0; j < e; j++) chk(m_u.got[j], base + j);
  endtask : finish_xfer

  task automatic xfer(input rcs_tgt_e t, input logic [4:0] n,
                      input logic [7:0] base, input int np);
    int e;
    int j;
    e = (n == 0) ? 1 : ((n > 19) ? 19 : n);
    m_u.got.delete();
    m_u.seen = 6'h00;
    rd_cnt = 0;
    for (j = 0; j < np; j++) begin
      wr_valid = 1'b1;
      wr_data = base + j;
      @(negedge clk_sys);
    end
    wr_valid = 1'b0;
    cmd = '{target: t, nbytes: n};
    cmd_valid = 1'b1;
    j = 0;
    do begin
      @(negedge clk_sys);
      j++;
    end while (cmd_ready !== 1'b0 && j < 100);
    cmd_valid = 1'b0;
    chk(busy, 1);
    finish_xfer(e, base);
    chk(m_u.seen, 6'h01 << t);
    chk(rd_cnt, (t == RCS_TGT_OPTION) ? e : 0);
    if (t == RCS_TGT_OPTION) chk(last_rd, 8'hA5);
  endtask : xfer

  initial begin
    rst_n = 1'b0;
    cmd_valid = 1'b0;
    wr_valid = 1'b0;
    wr_data = 8'h00;
    svc_want = 1'b0;
    cmd = '{target: RCS_TGT_SHARED, nbytes: 5'h00};
    repeat (3) @(negedge clk_sys);
    chk({cmd_ready, busy, spi_clk, sel_n}, {3'h0, 6'h3F});
    rst_n = 1'b1;
    repeat (2) @(negedge clk_sys);
    chk({cmd_ready, wr_ready, busy}, 3'h6);
    for (r = 0; r < 7; r++) begin
      xfer(tg[r], nb[r], 8'h10 * r, (nb[r] == 0) ? 1 : nb[r]);
    end
    // Fill the buffer until it refuses, then drain it with a clamped count of 19 and a 13-byte transfer.
    for (k = 0; k < 40 && wr_ready === 1'b1; k++) begin
      wr_valid = 1'b1;
      wr_data = k;
      @(negedge clk_sys);
    end
    wr_valid = 1'b0;
    chk(k, 32);
    xfer(RCS_TGT_SHARED, 5'h1F, 8'h00, 0);
    xfer(RCS_TGT_EXP2, 5'h0D, 8'h13, 0);
    m_u.got.delete();
    m_u.seen = 6'h00;
    rd_cnt = 0;
    svc_want = 1'b1;
    k = 0;
    while (busy !== 1'b1 && k < 100) begin
      @(negedge clk_sys);
      k++;
    end
    svc_want = 1'b0;
    finish_xfer(RCS_SVC_BYTES, RCS_IDLE_TX);
    chk(m_u.seen, 6'h20);
    chk(last_rd, 8'hA5);
    chk(m_u.stray, 0);
    results();
  end
endmodule : radio_controller_spi_bus_tb_top

/* test/rcs_periph_model.sv */
`timescale 1ns/1ps

// ***************************************************************
// Far side: peripherals and option board
// ***************************************************************
module rcs_periph_model #(
  parameter logic [7:0] REPLY = 8'hA5
) (
  input wire logic spi_clk, // Serial clock.
  input wire logic spi_mosi, // Outbound data.
  input wire logic [5:0] sel_n, // Selects, bit index is target.
  output logic spi_miso, // Inbound data.
  input wire logic svc_want, // Bench asks for service.
  output logic svc_request // Service request line.
);
  logic [7:0] sh;
  logic [5:0] seen;
  logic [7:0] got[$];
  int bits;
  int stray;
  int tx_i;

  assign svc_request = svc_want;

  initial begin
    spi_miso = 1'b0;
    seen = 6'h00;
    bits = 0;
    stray = 0;
    tx_i = 7;
  end

  always @(negedge (&sel_n)) begin
    tx_i = 7;
    spi_miso = REPLY[7];
  end

  // Released line shows the inverse of its last value.
  always @(posedge (&sel_n)) spi_miso = ~spi_miso;

  always @(posedge spi_clk) begin
    if (&sel_n) begin
      stray++;
    end else begin
      seen = seen | ~sel_n;
      sh = {sh[6:0], spi_mosi};
      bits++;
      if (bits % 8 == 0) got.push_back(sh);
    end
  end

  always @(negedge spi_clk) begin
    if (!(&sel_n)) begin
      tx_i = (tx_i + 7) % 8;
      spi_miso = REPLY[tx_i];
    end
  end
endmodule : rcs_periph_model
